// ### csfr_status_reg.sv
// Module: processor status register with ALU flags, reset causes and bank bit
`default_nettype none
`timescale 1ns/100ps

module csfr_status_reg (
    input  wire logic                   mclk_in,         // Core clock
    input  wire logic                   rst_b_in,        // Power-up reset
    // Flag update from the executing instruction
    input  wire csfr_pkg::csfr_op_e     op_in,           // Operation kind
    input  wire csfr_pkg::csfr_byte_t   file_in,         // File/literal operand
    input  wire csfr_pkg::csfr_byte_t   w_in,            // Working register
    input  wire csfr_pkg::csfr_byte_t   logic_res_in,    // Logic op result
    // Reset-cause events
    input  wire logic                   wdt_clear_in,    // Watchdog clear
    input  wire logic                   sleep_in,        // Halt instruction
    input  wire logic                   wdt_timeout_in,  // Watchdog expired
    // Data memory write port
    input  wire logic                   wr_en_in,        // Write strobe
    input  wire csfr_pkg::csfr_byte_t   wr_addr_in,      // Write address
    input  wire csfr_pkg::csfr_byte_t   wr_data_in,      // Write data
    // Data memory read port
    input  wire logic                   rd_en_in,        // Read strobe
    input  wire csfr_pkg::csfr_byte_t   rd_addr_in,      // Read address
    output csfr_pkg::csfr_byte_t        rd_data_out,     // Read data
    output logic                        rd_hit_out,      // Read matched
    // Direct addressing
    input  wire logic [6:0]             dir_offset_in,   // Offset in bank
    output csfr_pkg::csfr_byte_t        direct_addr_out, // Full data address
    // Status view
    output csfr_pkg::csfr_byte_t        flags_out,       // Register contents
    output logic                        bank_select_out  // Upper bank chosen
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    csfr_pkg::csfr_byte_t flags_q;       // Status register
    csfr_pkg::csfr_byte_t flags_d;       // Its next value
    csfr_pkg::csfr_byte_t rd_data_q;     // Registered read data
    logic                 rd_hit_q;      // Registered read match
    csfr_pkg::csfr_byte_t dir_addr_q;    // Registered direct address

    ////////////////////////////////////////////////////////////////////////
    // Address decode: both mappings hit regardless of bank
    wire logic wr_addr_match = (wr_addr_in == csfr_pkg::ADDR_BANK0)
                             || (wr_addr_in == csfr_pkg::ADDR_BANK1);
    wire logic rd_addr_match = (rd_addr_in == csfr_pkg::ADDR_BANK0)
                             || (rd_addr_in == csfr_pkg::ADDR_BANK1);
    wire logic wr_hit = wr_en_in && wr_addr_match;
    wire logic rd_hit = rd_en_in && rd_addr_match;

    // Write mask: reset-cause flags are never writable, and any flag-affecting
    // operation locks all three ALU flags, so clear-file keeps nibble and carry
    wire logic op_flags = (op_in != csfr_pkg::OP_NONE);
    csfr_pkg::csfr_byte_t alu_lock;      // ALU flags locked this cycle
    csfr_pkg::csfr_byte_t wr_mask;       // Bits the write may change
    assign alu_lock = {8{op_flags}} & (csfr_pkg::MSK_Z | csfr_pkg::MSK_DC | csfr_pkg::MSK_C);
    assign wr_mask  = {8{wr_hit}} & csfr_pkg::WR_MASK & ~alu_lock;

    ////////////////////////////////////////////////////////////////////////
    // Hardware flag sources
    csfr_pkg::csfr_byte_t alu_upd;       // ALU flag update mask
    csfr_pkg::csfr_byte_t alu_val;       // ALU flag values
    csfr_pkg::csfr_byte_t cause_upd;     // Reset-cause update mask
    csfr_pkg::csfr_byte_t cause_val;     // Reset-cause values

    // Zero, nibble overflow and carry from the operation
    csfr_alu_flags u_alu_flags (
        .op_in        (op_in),
        .file_in      (file_in),
        .w_in         (w_in),
        .logic_res_in (logic_res_in),
        .upd_out      (alu_upd),
        .val_out      (alu_val)
    );

    // Watchdog expiry and powerdown from core events
    csfr_reset_cause u_reset_cause (
        .wdt_clear_in   (wdt_clear_in),
        .sleep_in       (sleep_in),
        .wdt_timeout_in (wdt_timeout_in),
        .upd_out        (cause_upd),
        .val_out        (cause_val)
    );

    // Masks never overlap, so the two sources merge by OR
    csfr_pkg::csfr_byte_t hw_upd;
    csfr_pkg::csfr_byte_t hw_val;
    assign hw_upd = alu_upd | cause_upd;
    assign hw_val = (alu_val & alu_upd) | (cause_val & cause_upd);

    ////////////////////////////////////////////////////////////////////////
    // Per-bit next value: hardware update beats an instruction write
    for (genvar i = 0; i < csfr_pkg::DATA_W; i++) begin : g_bit
        assign flags_d[i] = hw_upd[i] ? hw_val[i]
                          : wr_mask[i] ? wr_data_in[i]
                          : flags_q[i];
    end

    // Status register; power-up sets both reset-cause flags
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_q <= csfr_pkg::RESET_VAL;
        end else begin
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data and match one cycle after the strobe
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_q <= '0;
            rd_hit_q  <= 1'b0;
        end else begin
            rd_data_q <= rd_hit ? flags_q : '0;
            rd_hit_q  <= rd_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direct address: bank bit on top of the instruction offset
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dir_addr_q <= '0;
        end else begin
            dir_addr_q <= {flags_q[csfr_pkg::BIT_BANK_SEL], dir_offset_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rd_data_out     = rd_data_q;
    assign rd_hit_out      = rd_hit_q;
    assign direct_addr_out = dir_addr_q;
    assign flags_out       = flags_q;
    assign bank_select_out = flags_q[csfr_pkg::BIT_BANK_SEL];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Independent reference sums for the checks
    logic [8:0] chk_add;                 // Add with carry out
    logic [8:0] chk_sub;                 // Subtract, bit 8 is borrow
    assign chk_add = {1'b0, file_in} + {1'b0, w_in};
    assign chk_sub = {1'b0, file_in} - {1'b0, w_in};

    // No reset-cause event this cycle
    wire logic no_cause = !wdt_clear_in && !sleep_in && !wdt_timeout_in;

    // Bank bit write lands when nothing else changes it
    a_write_bank_bit: assert property (
        wr_hit && no_cause
        |=> flags_q[csfr_pkg::BIT_BANK_SEL] == $past(wr_data_in[csfr_pkg::BIT_BANK_SEL]))
        else $error("bank bit write lost");

    // Add targeting the register keeps computed carry
    a_flag_write_blocked: assert property (
        wr_hit && op_in == csfr_pkg::OP_ADD
        |=> flags_q[csfr_pkg::BIT_C] == $past(chk_add[8]))
        else $error("written carry overrode add carry");

    // Rotate targeting the register keeps zero and nibble flags
    a_rotate_locks_flags: assert property (
        wr_hit && op_in == csfr_pkg::OP_ROTL
        |=> $stable(flags_q[csfr_pkg::BIT_Z:csfr_pkg::BIT_DC]))
        else $error("write reached zero or nibble flag on rotate");

    // Writes never touch the reset-cause flags
    a_readonly_cause: assert property (
        wr_hit && no_cause
        |=> flags_q[csfr_pkg::BIT_TO:csfr_pkg::BIT_PWRDN]
            == $past(flags_q[csfr_pkg::BIT_TO:csfr_pkg::BIT_PWRDN]))
        else $error("cause flags changed by write");

    // Clear-file pattern
    sequence s_clear_file;
        wr_hit && wr_data_in == '0 && op_in == csfr_pkg::OP_LOGIC
        && logic_res_in == '0 && no_cause;
    endsequence
    a_clear_file_pattern: assert property (
        s_clear_file
        |=> flags_q == {3'b000, $past(flags_q[4:3]), 1'b1, $past(flags_q[1:0])})
        else $error("clear-file pattern wrong");

    // Direct address follows the bank bit one cycle later
    a_bank_address: assert property (
        1'b1 |=> direct_addr_out == {$past(bank_select_out), $past(dir_offset_in)})
        else $error("direct address bank wrong");

    // Halt then time-out: both flags end clear
    sequence s_halt_then_timeout;
        sleep_in && !wdt_timeout_in && !wdt_clear_in
        ##1 wdt_timeout_in && !wdt_clear_in && !sleep_in;
    endsequence
    a_timeout_after_halt: assert property (
        s_halt_then_timeout
        |=> !flags_q[csfr_pkg::BIT_TO] && !flags_q[csfr_pkg::BIT_PWRDN])
        else $error("time-out after halt flags wrong");

    // Watchdog clear sets both flags
    a_wdt_clear_flags: assert property (
        wdt_clear_in && !wdt_timeout_in
        |=> flags_q[csfr_pkg::BIT_TO] && flags_q[csfr_pkg::BIT_PWRDN])
        else $error("watchdog clear flags wrong");

    // Halt sets expiry, clears powerdown
    a_halt_flags: assert property (
        sleep_in && !wdt_timeout_in && !wdt_clear_in
        |=> flags_q[csfr_pkg::BIT_TO] && !flags_q[csfr_pkg::BIT_PWRDN])
        else $error("halt flags wrong");

    // Zero flag follows the logic result
    a_zero_flag: assert property (
        op_in == csfr_pkg::OP_LOGIC
        |=> flags_q[csfr_pkg::BIT_Z] == ($past(logic_res_in) == '0))
        else $error("zero flag wrong");

    // Nibble flag holds outside add and subtract
    a_nibble_scope: assert property (
        !wr_hit && op_in != csfr_pkg::OP_ADD && op_in != csfr_pkg::OP_SUB
        |=> $stable(flags_q[csfr_pkg::BIT_DC]))
        else $error("nibble flag moved");

    // Subtract carry is inverted borrow
    a_sub_borrow: assert property (
        op_in == csfr_pkg::OP_SUB
        |=> flags_q[csfr_pkg::BIT_C] == !$past(chk_sub[8]))
        else $error("subtract carry polarity wrong");

    // Rotate left loads the bit shifted out
    a_rotate_carry: assert property (
        op_in == csfr_pkg::OP_ROTL
        |=> flags_q[csfr_pkg::BIT_C] == $past(file_in[7]))
        else $error("rotate carry wrong");

    // Upper mapping reads the register too
    a_dual_read: assert property (
        rd_en_in && rd_addr_in == csfr_pkg::ADDR_BANK1
        |=> rd_hit_out && rd_data_out == $past(flags_q))
        else $error("upper mapping read wrong");

endmodule

`default_nettype wire

// ### csfr_pkg.sv
// Package: status register constants, field layout and ALU operation kinds
`default_nettype none

package csfr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths and types
    localparam int DATA_W    = 8;             // Data path width
    localparam int NIB_W     = 4;             // Low nibble width
    localparam int DIR_OFS_W = 7;             // Direct address offset width

    typedef logic [DATA_W-1:0] csfr_byte_t;   // One data byte

    // Operation kinds as seen by the flag logic
    typedef enum logic [2:0] {
        OP_NONE,                              // No flag effect
        OP_LOGIC,                             // Zero flag only
        OP_ADD,                               // Add, all three flags
        OP_SUB,                               // Subtract, all three flags
        OP_ROTL,                              // Rotate left, carry only
        OP_ROTR                               // Rotate right, carry only
    } csfr_op_e;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam csfr_byte_t ADDR_BANK0 = 8'h03;   // Mapping in data bank 0
    localparam csfr_byte_t ADDR_BANK1 = 8'h83;   // Mapping in data bank 1

    // Field positions
    localparam int BIT_C   = 0;               // Carry / borrow
    localparam int BIT_DC  = 1;               // Nibble overflow flag
    localparam int BIT_Z   = 2;               // Zero
    localparam int BIT_PWRDN      = 3;        // Powerdown flag
    localparam int BIT_TO         = 4;        // Watchdog expiry flag
    localparam int BIT_BANK_SEL   = 5;        // Bank select bit
    localparam int BIT_UPPER_BANK = 6;        // Upper bank bit, reserved
    localparam int BIT_IND_PAGE   = 7;        // Indirect page bit, reserved

    // Field masks
    localparam csfr_byte_t MSK_C   = 8'h01;
    localparam csfr_byte_t MSK_DC  = 8'h02;
    localparam csfr_byte_t MSK_Z   = 8'h04;
    localparam csfr_byte_t MSK_PWRDN = 8'h08;
    localparam csfr_byte_t MSK_TO  = 8'h10;
    localparam csfr_byte_t WR_MASK = 8'he7;   // Bits an instruction may write

    // Power-up value: both reset-cause flags set, rest clear
    localparam csfr_byte_t RESET_VAL = 8'h18;

endpackage

`default_nettype wire

// ### csfr_alu_flags.sv
// Module: zero, nibble overflow and carry flag values from an ALU operation
`default_nettype none
`timescale 1ns/100ps

module csfr_alu_flags (
    input  wire csfr_pkg::csfr_op_e  op_in,         // Operation kind
    input  wire csfr_pkg::csfr_byte_t file_in,      // File or literal operand
    input  wire csfr_pkg::csfr_byte_t w_in,         // Working register operand
    input  wire csfr_pkg::csfr_byte_t logic_res_in, // Result of a logic op
    output logic [7:0]               upd_out,       // Bits hardware updates
    output logic [7:0]               val_out        // Values for those bits
);

    ////////////////////////////////////////////////////////////////////////
    // Operation decode
    wire logic is_add   = (op_in == csfr_pkg::OP_ADD);
    wire logic is_sub   = (op_in == csfr_pkg::OP_SUB);
    wire logic is_arith = is_add | is_sub;
    wire logic is_rotl  = (op_in == csfr_pkg::OP_ROTL);
    wire logic is_rotr  = (op_in == csfr_pkg::OP_ROTR);
    wire logic z_upd    = is_arith | (op_in == csfr_pkg::OP_LOGIC);
    wire logic c_upd    = is_arith | is_rotl | is_rotr;

    ////////////////////////////////////////////////////////////////////////
    // Adder: subtract adds the two's complement, so carry means no borrow
    csfr_pkg::csfr_byte_t opnd_b;    // Second operand, inverted for subtract
    logic [8:0]           sum9;      // Full sum with carry out
    logic [4:0]           low5;      // Low nibble sum with carry out
    csfr_pkg::csfr_byte_t res;       // Result the zero flag looks at

    assign opnd_b = is_sub ? ~w_in : w_in;
    assign sum9   = {1'b0, file_in} + {1'b0, opnd_b} + {8'h00, is_sub};
    assign low5   = {1'b0, file_in[csfr_pkg::NIB_W-1:0]}
                  + {1'b0, opnd_b[csfr_pkg::NIB_W-1:0]} + {4'h0, is_sub};
    assign res    = is_arith ? sum9[7:0] : logic_res_in;

    // Flag values
    wire logic zero = (res == '0);
    wire logic dcar = low5[csfr_pkg::NIB_W];
    wire logic car  = is_arith ? sum9[csfr_pkg::DATA_W]
                    : is_rotl  ? file_in[csfr_pkg::DATA_W-1]
                    : file_in[0];

    ////////////////////////////////////////////////////////////////////////
    // Pack into register bit positions; nibble flag only for add/subtract
    assign upd_out = ({8{z_upd}} & csfr_pkg::MSK_Z)
                   | ({8{is_arith}} & csfr_pkg::MSK_DC)
                   | ({8{c_upd}} & csfr_pkg::MSK_C);
    assign val_out = ({8{zero}} & csfr_pkg::MSK_Z)
                   | ({8{dcar}} & csfr_pkg::MSK_DC)
                   | ({8{car}} & csfr_pkg::MSK_C);

endmodule

`default_nettype wire

// ### csfr_reset_cause.sv
// Module: watchdog expiry and powerdown flag updates from core events
`default_nettype none
`timescale 1ns/100ps

module csfr_reset_cause (
    input  wire logic  wdt_clear_in,   // Watchdog clear instruction executes
    input  wire logic  sleep_in,       // Halt instruction executes
    input  wire logic  wdt_timeout_in, // Watchdog timer expired
    output logic [7:0] upd_out,        // Bits hardware updates
    output logic [7:0] val_out         // Values for those bits
);

    ////////////////////////////////////////////////////////////////////////
    // Expiry flag: set by clear or halt, cleared by time-out (time-out wins)
    wire logic to_upd = wdt_clear_in | sleep_in | wdt_timeout_in;
    wire logic to_val = ~wdt_timeout_in;

    // Powerdown flag: set by clear, cleared by halt
    wire logic pwrdn_upd = wdt_clear_in | sleep_in;
    wire logic pwrdn_val = ~sleep_in;

    ////////////////////////////////////////////////////////////////////////
    // Pack into register bit positions
    assign upd_out = ({8{to_upd}} & csfr_pkg::MSK_TO)
                   | ({8{pwrdn_upd}} & csfr_pkg::MSK_PWRDN);
    assign val_out = ({8{to_val}} & csfr_pkg::MSK_TO)
                   | ({8{pwrdn_val}} & csfr_pkg::MSK_PWRDN);

endmodule

`default_nettype wire

// ### csfr_core_model.sv
// Behavioural model of the core execution side feeding the status register
`timescale 1ns/100ps
`default_nettype none

module csfr_core_model (
    input  wire logic                 mclk_in,         // Core clock
    output var csfr_pkg::csfr_op_e    op_out,          // Operation kind
    output var csfr_pkg::csfr_byte_t  file_out,        // File or literal operand
    output var csfr_pkg::csfr_byte_t  w_out,           // Working register
    output var csfr_pkg::csfr_byte_t  logic_res_out,   // Logic result
    output var logic                  wdt_clear_out,   // Watchdog clear pulse
    output var logic                  sleep_out,       // Halt pulse
    output var logic                  wdt_timeout_out, // Time-out pulse
    output var logic                  wr_en_out,       // Write strobe
    output var csfr_pkg::csfr_byte_t  addr_out,        // Read and write address
    output var csfr_pkg::csfr_byte_t  wr_data_out,     // Write data
    output var logic                  rd_en_out,       // Read strobe
    output var logic [6:0]            dir_offset_out   // Direct offset
);
    ////////////////////////////////////////////////////////////////////////
    // Quiet core at time zero
    initial begin
        op_out = csfr_pkg::OP_NONE;
        {file_out, w_out, logic_res_out, addr_out, wr_data_out} = 40'h0;
        {wdt_clear_out, sleep_out, wdt_timeout_out, wr_en_out, rd_en_out} = 5'h0;
        dir_offset_out = 7'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // One instruction, launched just after an edge, held across the next
    task automatic drive(input csfr_pkg::csfr_op_e op, input csfr_pkg::csfr_byte_t f, input csfr_pkg::csfr_byte_t w,
                         input csfr_pkg::csfr_byte_t lr, input logic [1:0] acc, input csfr_pkg::csfr_byte_t a,
                         input csfr_pkg::csfr_byte_t d, input logic [2:0] ev);
        @(posedge mclk_in);
        #1;
        op_out = op;
        {file_out, w_out, logic_res_out} = {f, w, lr};
        {rd_en_out, wr_en_out} = acc;
        addr_out = a;
        dir_offset_out = a[6:0];
        wr_data_out = d & 8'h3f;
        {wdt_timeout_out, sleep_out, wdt_clear_out} = ev;
    endtask

    // Strobes drop; operands flip so a stale value never looks valid
    task automatic idle;
        @(posedge mclk_in);
        #1;
        op_out = csfr_pkg::OP_NONE;
        {wdt_timeout_out, sleep_out, wdt_clear_out, wr_en_out, rd_en_out} = 5'h0;
        {file_out, w_out, logic_res_out, wr_data_out} = ~{file_out, w_out, logic_res_out, wr_data_out};
    endtask
endmodule

`default_nettype wire

// ### csfr_tb.sv
// Self-checking testbench for the status register block
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic                  mclk_in;                        // Core clock
    logic                  rst_b_in;                       // Power-up reset
    csfr_pkg::csfr_op_e    op;                             // Operation kind
    csfr_pkg::csfr_byte_t  file_v, w_v, lres_v, addr_v;    // Operands, address
    csfr_pkg::csfr_byte_t  wdata_v, rd_data, direct, flags; // Data paths
    logic                  clr, slp, tmo, wr_en, rd_en;    // Strobes and events
    logic                  rd_hit, bank;                   // Status outputs
    logic [6:0]            dir_off;                        // Direct offset
    csfr_pkg::csfr_byte_t  exp_f;                          // Expected contents
    int                    errors = 0;                     // Mismatch count
    int                    checked = 0;                    // Compare count

    ////////////////////////////////////////////////////////////////////////
    // Clock, core model and block under test
    initial mclk_in = 1'b0;
    always #4 mclk_in = ~mclk_in;

    csfr_core_model core (.mclk_in(mclk_in), .op_out(op), .file_out(file_v), .w_out(w_v), .logic_res_out(lres_v),
        .wdt_clear_out(clr), .sleep_out(slp), .wdt_timeout_out(tmo), .wr_en_out(wr_en), .addr_out(addr_v),
        .wr_data_out(wdata_v), .rd_en_out(rd_en), .dir_offset_out(dir_off));

    csfr_status_reg dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .op_in(op), .file_in(file_v), .w_in(w_v),
        .logic_res_in(lres_v), .wdt_clear_in(clr), .sleep_in(slp), .wdt_timeout_in(tmo), .wr_en_in(wr_en),
        .wr_addr_in(addr_v), .wr_data_in(wdata_v), .rd_en_in(rd_en), .rd_addr_in(addr_v), .rd_data_out(rd_data),
        .rd_hit_out(rd_hit), .dir_offset_in(dir_off), .direct_addr_out(direct), .flags_out(flags),
        .bank_select_out(bank));

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input csfr_pkg::csfr_byte_t seen, input csfr_pkg::csfr_byte_t want, input string what);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    // Instruction cycle followed by one quiet cycle
    task automatic instr(input csfr_pkg::csfr_op_e o, input csfr_pkg::csfr_byte_t f, input csfr_pkg::csfr_byte_t w,
                         input csfr_pkg::csfr_byte_t lr, input logic wr, input csfr_pkg::csfr_byte_t a,
                         input csfr_pkg::csfr_byte_t d, input logic [2:0] ev);
        core.drive(o, f, w, lr, {1'b0, wr}, a, d, ev);
        core.idle();
    endtask

    task automatic read_chk(input csfr_pkg::csfr_byte_t a, input logic hit);
        core.drive(csfr_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 2'b10, a, 8'h00, 3'b000);
        core.idle();
        chk({7'h00, rd_hit}, {7'h00, hit}, "read hit");
        chk(rd_data, hit ? exp_f : 8'h00, "read data");
    endtask

    // Flags an operation should leave, worked out from the flag rules
    function automatic csfr_pkg::csfr_byte_t alu_exp(input csfr_pkg::csfr_op_e o, input csfr_pkg::csfr_byte_t f,
            input csfr_pkg::csfr_byte_t w, input csfr_pkg::csfr_byte_t lr, input csfr_pkg::csfr_byte_t prev);
        logic [8:0]           full;   // Byte sum with carry
        logic [4:0]           nib;    // Nibble sum with carry
        csfr_pkg::csfr_byte_t r;      // Result flags
        r = prev;
        full = (o == csfr_pkg::OP_SUB) ? {1'b0, f} + {1'b0, ~w} + 9'h001 : {1'b0, f} + {1'b0, w};
        nib = (o == csfr_pkg::OP_SUB) ? {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01 : {1'b0, f[3:0]} + {1'b0, w[3:0]};
        case (o)
            csfr_pkg::OP_ADD, csfr_pkg::OP_SUB: r[2:0] = {full[7:0] == 8'h00, nib[4], full[8]};
            csfr_pkg::OP_LOGIC: r[2] = (lr == 8'h00);
            csfr_pkg::OP_ROTL: r[0] = f[7];
            csfr_pkg::OP_ROTR: r[0] = f[0];
            default: r = prev;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        exp_f = 8'h18;
        chk(flags, exp_f, "reset flags");
        chk({7'h00, bank}, 8'h00, "reset bank");
        $display("test reset done");
    endtask

    task automatic t_regs;
        instr(csfr_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 1'b1, 8'h03, 8'h27, 3'b000);
        exp_f = 8'h3f;
        chk(flags, exp_f, "plain write");
        chk({7'h00, bank}, 8'h01, "bank set");
        chk(direct, 8'h03, "direct old bank");
        core.idle();
        chk(direct, 8'h83, "direct new bank");
        read_chk(8'h03, 1'b1);
        read_chk(8'h83, 1'b1);
        read_chk(8'h04, 1'b0);
        instr(csfr_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 1'b1, 8'h04, 8'h00, 3'b000);
        chk(flags, exp_f, "foreign address");
        instr(csfr_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 1'b1, 8'h83, 8'h00, 3'b000);
        exp_f = 8'h18;
        chk(flags, exp_f, "clear write keeps causes");
        chk({7'h00, bank}, 8'h00, "bank clear");
        $display("test registers done");
    endtask

    task automatic t_alu;
        logic [26:0] tbl [0:10];   // Operation, file, w, logic result
        tbl = '{{csfr_pkg::OP_ADD, 24'h0f0100}, {csfr_pkg::OP_ADD, 24'hf01000}, {csfr_pkg::OP_SUB, 24'h050500},
                {csfr_pkg::OP_SUB, 24'h000100}, {csfr_pkg::OP_SUB, 24'h100100}, {csfr_pkg::OP_LOGIC, 24'hffff00},
                {csfr_pkg::OP_LOGIC, 24'h00005a}, {csfr_pkg::OP_ROTL, 24'h800000}, {csfr_pkg::OP_ROTR, 24'hfe0000},
                {csfr_pkg::OP_ROTR, 24'h010000}, {csfr_pkg::OP_NONE, 24'h000000}};
        for (int i = 0; i < 11; i++) begin
            instr(csfr_pkg::csfr_op_e'(tbl[i][26:24]), tbl[i][23:16], tbl[i][15:8], tbl[i][7:0], 1'b0,
                  8'h00, 8'h00, 3'b000);
            exp_f = alu_exp(csfr_pkg::csfr_op_e'(tbl[i][26:24]), tbl[i][23:16], tbl[i][15:8], tbl[i][7:0], exp_f);
            chk(flags, exp_f, "alu flags");
        end
        $display("test alu done");
    endtask

    task automatic t_override;
        instr(csfr_pkg::OP_ADD, 8'h0f, 8'h01, 8'h00, 1'b1, 8'h03, 8'h25, 3'b000);
        exp_f = (alu_exp(csfr_pkg::OP_ADD, 8'h0f, 8'h01, 8'h00, exp_f) & 8'h1f) | 8'h20;
        chk(flags, exp_f, "add beats write");
        instr(csfr_pkg::OP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b1, 8'h83, 8'h00, 3'b000);
        exp_f = (exp_f & 8'h1b) | 8'h04;
        chk(flags, exp_f, "clear file");
        instr(csfr_pkg::OP_ROTL, 8'h80, 8'h00, 8'h00, 1'b1, 8'h03, 8'h00, 3'b000);
        exp_f = (exp_f & 8'h1e) | 8'h01;
        chk(flags, exp_f, "rotate beats write");
        $display("test override done");
    endtask

    task automatic t_causes;
        logic [4:0] evs [0:4];   // Event set and expected expiry, powerdown
        evs = '{5'b010_10, 5'b100_00, 5'b001_11, 5'b101_01, 5'b010_10};
        for (int i = 0; i < 5; i++) begin
            instr(csfr_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, evs[i][4:2]);
            exp_f[4:3] = evs[i][1:0];
            chk(flags, exp_f, "reset cause");
        end
        instr(csfr_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 1'b1, 8'h03, 8'h18, 3'b000);
        exp_f = {3'b000, exp_f[4:3], 3'b000};
        chk(flags, exp_f, "causes read only");
        $display("test causes done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_b_in = 1'b0;
        repeat (6) @(posedge mclk_in);
        #1;
        rst_b_in = 1'b1;
        t_reset();
        t_regs();
        t_alu();
        t_override();
        t_causes();
        close_out();
    end

    // About 60 cycles of tests; give them 400, over six times that
    initial begin
        #(8 * 400);
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end
endmodule

`default_nettype wire
